// ### shared/rcl_regs.vh
// Purpose: Register offsets, field positions, reset values and timing constants of the
//          resonant cycle limit and second drive output edge block.
// Assumes: Byte-wide registers at the offsets below, one clock at 125 MHz.
// Notes:   Definitions only; included by bare name.
`ifndef RCL_REGS_VH
`define RCL_REGS_VH

// Register offsets.
`define RCL_FREQ_SETTING_OFS          8'h40
`define RCL_MAX_CYCLE_HIGH_BYTE_OFS   8'h42
`define RCL_MAX_CYCLE_LOW_NIBBLE_OFS  8'h44
`define RCL_RISE_DELAY_OFS            8'h45
`define RCL_MIN_CYCLE_HIGH_BYTE_OFS   8'h46
`define RCL_FALL_OFFSET_OFS           8'h47
`define RCL_MIN_CYCLE_LOW_NIBBLE_OFS  8'h48

// Base of the decoded window and its number of byte slots.
`define RCL_WINDOW_BASE               8'h40
`define RCL_WINDOW_SLOTS              9

// Field positions.
`define RCL_FREQ_FIELD_MSB            5
`define RCL_FREQ_FIELD_LSB            0
`define RCL_NIBBLE_MSB                7
`define RCL_NIBBLE_LSB                4
`define RCL_FALL_LEAD_BIT             7

// Value of the frequency field that selects resonant operation.
`define RCL_RESONANT_CODE             6'h3f

// Reset values; the limits open fully so a clamp never bites before software sets them.
`define RCL_FREQ_SETTING_RST          8'h00
`define RCL_MAX_HIGH_RST              8'hff
`define RCL_MAX_LOW_RST               8'hf0
`define RCL_MIN_HIGH_RST              8'h00
`define RCL_MIN_LOW_RST               8'h00
`define RCL_RISE_DELAY_RST            8'h00
`define RCL_FALL_OFFSET_RST           8'h00

// Timing: one setting count is 5 ns, one clock is 8 ns.
`define RCL_NS_PER_COUNT              5
`define RCL_CLK_PERIOD_NS             8
`define RCL_LEAD_SPAN                 256

`endif

// ### verilog/rcl_reg_file.v
// Purpose: Byte register storage for the resonant cycle limit block.
// Assumes: One write strobe per byte; writes are taken on the clock edge.
// Notes:   Reserved bits are stored and read back like the rest of the byte.
`timescale 1ns/1ps
`default_nettype none
`include "rcl_regs.vh"

module rcl_reg_file (
  input  wire        clk,
  input  wire        nrst,
  input  wire [7:0]  wr_addr,
  input  wire [7:0]  wr_data,
  input  wire        wr_en,
  input  wire [7:0]  rd_addr,
  output reg  [7:0]  rd_data,
  output reg         rd_hit,
  output wire [71:0] flat
);

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Decoding shared by the write and read sides.
  function slot_mapped;
    input [7:0] a;
    begin
      slot_mapped = (a == `RCL_FREQ_SETTING_OFS) || (a == `RCL_MAX_CYCLE_HIGH_BYTE_OFS) ||
                    (a == `RCL_MAX_CYCLE_LOW_NIBBLE_OFS) || (a == `RCL_RISE_DELAY_OFS) ||
                    (a == `RCL_MIN_CYCLE_HIGH_BYTE_OFS) || (a == `RCL_FALL_OFFSET_OFS) ||
                    (a == `RCL_MIN_CYCLE_LOW_NIBBLE_OFS);
    end
  endfunction

  function [7:0] slot_reset;
    input [3:0] i;
    begin
      case (i)
        4'h2:    slot_reset = `RCL_MAX_HIGH_RST;
        4'h4:    slot_reset = `RCL_MAX_LOW_RST;
        4'h5:    slot_reset = `RCL_RISE_DELAY_RST;
        4'h6:    slot_reset = `RCL_MIN_HIGH_RST;
        4'h7:    slot_reset = `RCL_FALL_OFFSET_RST;
        4'h8:    slot_reset = `RCL_MIN_LOW_RST;
        default: slot_reset = `RCL_FREQ_SETTING_RST;
      endcase
    end
  endfunction

  wire [7:0] wr_index;
  wire [7:0] rd_index;
  assign wr_index = wr_addr - `RCL_WINDOW_BASE;
  assign rd_index = rd_addr - `RCL_WINDOW_BASE;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // One byte per slot; unmapped slots never store and read as zero.
  genvar g;
  generate
    for (g = 0; g < `RCL_WINDOW_SLOTS; g = g + 1) begin : slot
      // Slot address and index are held at full width and cut on purpose for the decoders.
      localparam [31:0] slot_addr = `RCL_WINDOW_BASE + g;
      localparam [31:0] slot_idx  = g;
      reg [7:0] value;
      always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          value <= slot_reset(slot_idx[3:0]);
        end else if (wr_en && slot_mapped(wr_addr) && (wr_index == g)) begin
          value <= wr_data;
        end
      end
      assign flat[g*8 +: 8] = slot_mapped(slot_addr[7:0]) ? value : 8'h00;
    end
  endgenerate

  // Read mux over the flattened storage.
  always @* begin
    rd_hit  = slot_mapped(rd_addr);
    rd_data = 8'h00;
    if (rd_hit) begin
      rd_data = flat[rd_index[3:0]*8 +: 8];
    end
  end

endmodule
`default_nettype wire

// ### verilog/rcl_resonant_timing.v
// Purpose: Resonant mode switching timebase with cycle limits and second drive output edges.
// Assumes: Register port is the internal side of the two-wire bus engine; 125 MHz clock.
// Notes:   Times are tracked in ns stepping by the 8 ns clock, so 5 ns settings round up
//          to the next clock edge at which the elapsed time reaches them.
`timescale 1ns/1ps
`default_nettype none
`include "rcl_regs.vh"

module rcl_resonant_timing (
  input  wire        clk,
  input  wire        nrst,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  output reg         reg_rvalid,
  output reg         reg_unmapped,
  input  wire [11:0] requested_cycle,
  output reg         second_drive_output,
  output reg         cycle_start_instant,
  output reg         resonant_active,
  output reg  [11:0] applied_cycle
);

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Register storage.
  wire [71:0] regs_flat;
  wire [7:0]  rd_byte;
  wire        rd_hit;

  rcl_reg_file u_regs (
    .clk     (clk),
    .nrst    (nrst),
    .wr_addr (reg_addr),
    .wr_data (reg_wdata),
    .wr_en   (reg_wr),
    .rd_addr (reg_addr),
    .rd_data (rd_byte),
    .rd_hit  (rd_hit),
    .flat    (regs_flat)
  );

  // Read answers one clock after the strobe; unmapped offsets return zero.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata    <= 8'h00;
      reg_rvalid   <= 1'b0;
      reg_unmapped <= 1'b0;
    end else begin
      reg_rvalid   <= reg_rd;
      reg_rdata    <= reg_rd ? rd_byte : 8'h00;
      reg_unmapped <= (reg_rd || reg_wr) && !rd_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Field extraction.
  wire [7:0] freq_setting;
  wire [7:0] max_high;
  wire [7:0] max_low;
  wire [7:0] rise_delay;
  wire [7:0] min_high;
  wire [7:0] fall_offset;
  wire [7:0] min_low;

  assign freq_setting = regs_flat[0*8 +: 8];
  assign max_high     = regs_flat[2*8 +: 8];
  assign max_low      = regs_flat[4*8 +: 8];
  assign rise_delay   = regs_flat[5*8 +: 8];
  assign min_high     = regs_flat[6*8 +: 8];
  assign fall_offset  = regs_flat[7*8 +: 8];
  assign min_low      = regs_flat[8*8 +: 8];

  // Limits assemble as upper byte times 16 plus the top nibble of the lower register.
  wire [11:0] max_cycle;
  wire [11:0] min_cycle;
  assign max_cycle = {max_high, max_low[`RCL_NIBBLE_MSB:`RCL_NIBBLE_LSB]};
  assign min_cycle = {min_high, min_low[`RCL_NIBBLE_MSB:`RCL_NIBBLE_LSB]};

  // Only the all-ones frequency code selects resonant operation.
  wire mode_on;
  assign mode_on =
    (freq_setting[`RCL_FREQ_FIELD_MSB:`RCL_FREQ_FIELD_LSB] == `RCL_RESONANT_CODE);

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Period clamp. A minimum set above the maximum is resolved in favour of the maximum,
  // since a cycle too short is safer for the power stage than one too long.
  reg [11:0] next_cycle;
  always @* begin
    next_cycle = requested_cycle;
    if (requested_cycle < min_cycle) begin
      next_cycle = min_cycle;
    end
    if (next_cycle > max_cycle) begin
      next_cycle = max_cycle;
    end
  end

  // Conversion of counts to ns; every count is 5 ns.
  wire [15:0] next_period_ns;
  wire [15:0] next_rise_ns;
  wire [15:0] next_mid_ns;
  wire [15:0] trail_ns;
  wire [15:0] lead_ns;
  reg  [15:0] next_fall_ns;

  // Products are formed at integer width and cut to 16 bits; 4095 counts of 5 ns still fit.
  wire [31:0] period_prod;
  wire [31:0] rise_prod;
  wire [31:0] trail_prod;
  wire [31:0] lead_prod;
  assign period_prod    = next_cycle * `RCL_NS_PER_COUNT;
  assign rise_prod      = rise_delay * `RCL_NS_PER_COUNT;
  assign trail_prod     = fall_offset * `RCL_NS_PER_COUNT;
  assign lead_prod      = (`RCL_LEAD_SPAN - fall_offset) * `RCL_NS_PER_COUNT;
  assign next_period_ns = period_prod[15:0];
  assign next_rise_ns   = rise_prod[15:0];
  assign next_mid_ns    = {1'b0, next_period_ns[15:1]};
  assign trail_ns       = trail_prod[15:0];
  assign lead_ns        = lead_prod[15:0];

  // Settings 0x80 and above lead the midpoint; a lead past the cycle start pins to zero.
  always @* begin
    next_fall_ns = next_mid_ns + trail_ns;
    if (fall_offset[`RCL_FALL_LEAD_BIT]) begin
      next_fall_ns = (lead_ns > next_mid_ns) ? 16'h0000 : (next_mid_ns - lead_ns);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Timebase. Edge and period targets are latched at each cycle start, so a register
  // write to the limit, rise delay or fall offset registers in mid-cycle never tears the current pulse.
  reg  [15:0] phase_ns;
  reg  [15:0] period_ns;
  reg  [15:0] rise_ns;
  reg  [15:0] fall_ns;
  wire [31:0] phase_sum;
  wire [15:0] phase_step;
  wire        wrap;

  assign phase_sum  = phase_ns + `RCL_CLK_PERIOD_NS;
  assign phase_step = phase_sum[15:0];
  assign wrap       = !resonant_active || (phase_step >= period_ns);

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase_ns            <= 16'h0000;
      period_ns           <= 16'h0000;
      rise_ns             <= 16'h0000;
      fall_ns             <= 16'h0000;
      applied_cycle       <= 12'h000;
      resonant_active     <= 1'b0;
      cycle_start_instant <= 1'b0;
    end else begin
      resonant_active <= mode_on;
      if (mode_on && wrap) begin
        phase_ns            <= 16'h0000;
        period_ns           <= next_period_ns;
        rise_ns             <= next_rise_ns;
        fall_ns             <= next_fall_ns;
        applied_cycle       <= next_cycle;
        cycle_start_instant <= 1'b1;
      end else begin
        phase_ns            <= mode_on ? phase_step : 16'h0000;
        cycle_start_instant <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Second drive output: high from the rise instant until the fall instant of each cycle.
  // The output is evaluated on the phase the counter is about to take, so it stays aligned
  // with the cycle start strobe.
  reg [15:0] next_phase;
  reg [15:0] use_rise;
  reg [15:0] use_fall;
  always @* begin
    next_phase = phase_step;
    use_rise   = rise_ns;
    use_fall   = fall_ns;
    if (wrap) begin
      next_phase = 16'h0000;
      use_rise   = next_rise_ns;
      use_fall   = next_fall_ns;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      second_drive_output <= 1'b0;
    end else begin
      second_drive_output <= mode_on && (next_phase >= use_rise)
                             && (next_phase < use_fall);
    end
  end

endmodule
`default_nettype wire

// ### testbench/rcl_timing_props.sv
// Purpose: Checker for the register port and timebase of the resonant timing block.
// Assumes: Sees only the ports; byte writes land on the strobe edge.
// Notes:   Limits are shadowed from writes because the ports do not show them.
`timescale 1ns/1ps
`default_nettype none
`include "rcl_regs.vh"
module rcl_timing_props (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        reg_rvalid,
  input wire logic        reg_unmapped,
  input wire logic [11:0] requested_cycle,
  input wire logic        second_drive_output,
  input wire logic        cycle_start_instant,
  input wire logic        resonant_active,
  input wire logic [11:0] applied_cycle
);
  logic [7:0]  mx_h, mx_l, mn_h, mn_l;
  logic [11:0] lo, ex;
  logic [15:0] cnt, len;
  logic        armed;
  wire         hole = reg_addr < 8'h40 || reg_addr > 8'h48 ||
                      reg_addr == 8'h41 || reg_addr == 8'h43;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////
  // Minimum first, so the maximum wins when the limits cross.
  always_comb begin
    lo = (requested_cycle < {mn_h, mn_l[7:4]}) ? {mn_h, mn_l[7:4]} : requested_cycle;
    ex = (lo > {mx_h, mx_l[7:4]}) ? {mx_h, mx_l[7:4]} : lo;
  end
  // Shadow limits and clocks since the last cycle start.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mx_h  <= `RCL_MAX_HIGH_RST;
      mx_l  <= `RCL_MAX_LOW_RST;
      mn_h  <= `RCL_MIN_HIGH_RST;
      mn_l  <= `RCL_MIN_LOW_RST;
      cnt   <= 16'h0000;
      len   <= 16'h0001;
      armed <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == 8'h42) mx_h <= reg_wdata;
      if (reg_wr && reg_addr == 8'h44) mx_l <= reg_wdata;
      if (reg_wr && reg_addr == 8'h46) mn_h <= reg_wdata;
      if (reg_wr && reg_addr == 8'h48) mn_l <= reg_wdata;
      cnt   <= cycle_start_instant ? 16'h0001 : cnt + 16'h0001;
      armed <= resonant_active && (armed || cycle_start_instant);
      if (cycle_start_instant) len <= ({4'h0, applied_cycle} * 16'h0005 + 16'h0007) >> 3;
    end
  end
  ////////////////////////////////////////////////////////////
  a_read_answer: assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
  a_no_stray: assert property (!reg_rd |=> !reg_rvalid) else $error("stray read valid");
  a_hole_flagged: assert property ((reg_wr || reg_rd) && hole |=> reg_unmapped)
    else $error("unmapped access not flagged");
  a_mapped_quiet: assert property (!((reg_wr || reg_rd) && hole) |=> !reg_unmapped)
    else $error("unmapped flag without cause");
  a_hole_zero: assert property (reg_rd && hole |=> reg_rdata == 8'h00) else $error("hole read");
  a_off_idle: assert property (!resonant_active |->
    !cycle_start_instant && !second_drive_output) else $error("activity while resonant mode off");
  a_first_start: assert property ($rose(resonant_active) |-> cycle_start_instant)
    else $error("no start at mode entry");
  a_applied_clamp: assert property (cycle_start_instant |->
    applied_cycle == $past(ex)) else $error("applied period not clamped");
  a_start_spacing: assert property (cycle_start_instant && armed |->
    cnt == (len == 16'h0000 ? 16'h0001 : len)) else $error("cycle length wrong");
  c_start: cover property (cycle_start_instant && armed);
  c_drive: cover property ($rose(second_drive_output));
  c_hole: cover property (reg_unmapped);
endmodule
bind rcl_resonant_timing rcl_timing_props rcl_timing_props_inst (.clk(clk), .nrst(nrst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_unmapped(reg_unmapped),
  .requested_cycle(requested_cycle), .second_drive_output(second_drive_output),
  .cycle_start_instant(cycle_start_instant), .resonant_active(resonant_active),
  .applied_cycle(applied_cycle));
`default_nettype wire

// ### testbench/rcl_gate_drv_model.sv
// Purpose: Gate driver stand-in that times the second drive output's pulses.
// Assumes: Shares the block's clock; the drive input is a registered level.
// Notes:   Widths are whole clocks, the finest this driver can resolve.
`timescale 1ns/1ps
`default_nettype none
module rcl_gate_drv_model (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        drive,
  output var  logic [15:0] last_width
);
  logic [15:0] run;
  // Count each high pulse and keep the length of the last finished one.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      run        <= 16'h0000;
      last_width <= 16'h0000;
    end else if (drive) begin
      run <= run + 16'h0001;
    end else if (run != 16'h0000) begin
      last_width <= run;
      run        <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

// ### testbench/resonant_cycle_limits_and_output_b_edges_test.sv
// Purpose: Register and timebase test of the resonant timing block.
// Assumes: Inputs change at the falling edge; answers come one clock after a strobe.
// Notes:   Pulse widths are taken from the gate driver model, in whole clocks.
`timescale 1ns/1ps
`default_nettype none
module resonant_cycle_limits_and_output_b_edges_test;
  logic        clk, nrst, reg_wr, reg_rd;
  logic [7:0]  reg_addr, reg_wdata;
  logic [11:0] requested_cycle;
  wire  [7:0]  reg_rdata;
  wire  [11:0] applied_cycle;
  wire  [15:0] width_seen;
  wire         reg_rvalid, reg_unmapped, drv, cycle_start_instant, resonant_active;
  int          n_errors = 0;
  int          n_tests = 0;
  logic [7:0]  rst_val [9] = '{8'h00, 8'h00, 8'hff, 8'h00, 8'hf0, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0]  fall_set [4] = '{8'h00, 8'hf0, 8'h7f, 8'h80};
  rcl_resonant_timing rcl_resonant_timing_inst (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .reg_unmapped(reg_unmapped), .requested_cycle(requested_cycle),
    .second_drive_output(drv), .cycle_start_instant(cycle_start_instant),
    .resonant_active(resonant_active), .applied_cycle(applied_cycle));
  rcl_gate_drv_model rcl_gate_drv_model_inst (.clk(clk), .nrst(nrst), .drive(drv),
    .last_width(width_seen));
  ////////////////////////////////////////////////////////////
  // Free-running 125 MHz clock.
  initial clk = 1'b0;
  always #4 clk = ~clk;
  task automatic summarize();
    if (n_errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    chk("rvalid", {15'h0000, reg_rvalid}, 16'h0001);
    chk("rdata", {8'h00, reg_rdata}, {8'h00, exp});
  endtask
  // Bounded wait for a number of cycle starts; a hang ends the run.
  task automatic wait_starts(input int n);
    int k;
    k = 0;
    while (n > 0) begin
      @(negedge clk);
      if (cycle_start_instant === 1'b1) n--;
      k++;
      if (k > 5000) begin
        n_errors++;
        summarize();
      end
    end
  endtask
  // High clocks per cycle: rise after the start, fall about the midpoint.
  function automatic int width(int per, int rise, int fo);
    int p, f, w;
    p = per * 5;
    f = (fo < 128) ? p / 2 + fo * 5 : p / 2 - (256 - fo) * 5;
    w = 0;
    for (int ph = 0; ph < p; ph += 8) if (ph >= rise * 5 && ph < f) w++;
    return w;
  endfunction
  ////////////////////////////////////////////////////////////
  initial begin
    {nrst, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    requested_cycle = 12'h064;
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    for (int i = 0; i < 9; i++) rd(8'h40 + 8'(i), rst_val[i]);
    rd(8'h4a, 8'h00);
    chk("unmapped", {15'h0000, reg_unmapped}, 16'h0001);
    wr(8'h41, 8'h55);
    chk("unmapped", {15'h0000, reg_unmapped}, 16'h0001);
    rd(8'h41, 8'h00);
    chk("unmapped", {15'h0000, reg_unmapped}, 16'h0001);
    wr(8'h42, 8'ha0);
    wr(8'h44, 8'hf5);
    wr(8'h46, 8'h10);
    wr(8'h48, 8'h93);
    wr(8'h45, 8'h02);
    rd(8'h44, 8'hf5);
    chk("unmapped", {15'h0000, reg_unmapped}, 16'h0000);
    wr(8'h40, 8'h3e);
    repeat (20) @(negedge clk);
    chk("active", {15'h0000, resonant_active}, 16'h0000);
    wr(8'h40, 8'hff);
    rd(8'h40, 8'hff);
    chk("active", {15'h0000, resonant_active}, 16'h0001);
    foreach (fall_set[i]) begin
      wr(8'h47, fall_set[i]);
      wait_starts(3);
      chk("applied", {4'h0, applied_cycle}, 16'h0109);
      chk("width", width_seen, 16'(width(265, 2, fall_set[i])));
    end
    requested_cycle = 12'hfa0;
    wait_starts(2);
    chk("applied", {4'h0, applied_cycle}, 16'h0a0f);
    requested_cycle = 12'h3e8;
    wait_starts(2);
    chk("applied", {4'h0, applied_cycle}, 16'h03e8);
    wr(8'h46, 8'hff);
    wait_starts(2);
    chk("applied", {4'h0, applied_cycle}, 16'h0a0f);
    wr(8'h40, 8'h00);
    repeat (4) @(negedge clk);
    chk("drive", {15'h0000, drv}, 16'h0000);
    summarize();
  end
endmodule
`default_nettype wire
